// ==== core/gsr_defs.svh ====
// Constants for the status reporting block
`ifndef GSR_DEFS_SVH
`define GSR_DEFS_SVH
`define GSR_EV_OPC     0
`define GSR_EV_QYE     2
`define GSR_EV_DDE     3
`define GSR_EV_EXE     4
`define GSR_EV_CME     5
`define GSR_EV_PON     7
`define GSR_EV_USED    8'hBD
`define GSR_STB_TSB    3
`define GSR_STB_MAV    4
`define GSR_STB_ESB    5
`define GSR_STB_MSS    6
`define GSR_LINE_MAX   80
`define GSR_BYTE_ZERO  8'h00
`define GSR_CNT_W      7
`endif

// ==== core/gsr_pkg.sv ====
// Types for the status reporting block
`default_nettype none
package gsr_pkg;
   typedef enum logic [3:0] {
      GSR_CMD_NONE     = 4'h0,
      GSR_CMD_OPC      = 4'h1,
      GSR_CMD_RST      = 4'h2,
      GSR_CMD_CLS      = 4'h3,
      GSR_CMD_ESE      = 4'h4,
      GSR_CMD_ESE_Q    = 4'h5,
      GSR_CMD_ESR_Q    = 4'h6,
      GSR_CMD_SRE      = 4'h7,
      GSR_CMD_SRE_Q    = 4'h8,
      GSR_CMD_STB_Q    = 4'h9,
      GSR_CMD_TSE      = 4'hA,
      GSR_CMD_TSE_Q    = 4'hB,
      GSR_CMD_TSR_Q    = 4'hC,
      GSR_CMD_LRN_Q    = 4'hD,
      GSR_CMD_OTHER_Q  = 4'hE
   } gsr_cmd_e;
   typedef enum logic [1:0] {
      GSR_OC_IDLE = 2'b00,
      GSR_OC_ARM  = 2'b01
   } gsr_oc_e;
endpackage : gsr_pkg
`default_nettype wire

// ==== core/gsr_summary.sv ====
// Masked OR reduction of an event byte to one summary bit
`default_nettype none
module gsr_summary #(
   parameter int W = 8
) (
   input  wire logic [W-1:0] flags,
   input  wire logic [W-1:0] enables,
   output logic              summary
);
   initial begin
      if (W < 1) $error("gsr_summary: W must be positive");
   end
   assign summary = |(flags & enables);
endmodule : gsr_summary
`default_nettype wire

// ==== core/gsr_core.sv ====
// Status reporting, service request and message exchange control
`include "gsr_defs.svh"
`default_nettype none
// Operation
// - Raise service request while an enabled summary condition exists.
// - Drop service request after serial poll or when conditions clear.
// - Operation complete flag set only by the operation-complete command.
// - Query error: no output, any command while output unread, unterminated query.
// - Device error on lost input data or line buffer overflow.
// - Execution error on range, parameter count or device condition.
// - Command error on unknown command or invalid bus command.
// - Power-on flag set at power-up; request and user bits unused.
// - Standard summary follows any enabled event flag, recomputed continuously.
// - Test summary follows any enabled test event, recomputed continuously.
// - All three enable masks clear to zero on power-up.
// - Commands write and read test enable; query returns test events.
// - Fresh input buffer per command line, at most eighty characters.
// - Query response generated at parse time, not at read time.
// - Only the learn query returns several response units.
// - Reset command restores defaults and idles completion state machines.
// - Commands run sequentially; completion signalled right after each operation-complete command.
// - Power-up restores saved settings, or factory defaults if corrupted.
module gsr_core #(
   parameter int LINE_MAX = `GSR_LINE_MAX,
   parameter int SET_W    = 8
) (
   input  wire logic                clock,
   input  wire logic                rst_b,
   input  wire logic                rx_char_valid,
   input  wire logic                rx_char_term,
   input  wire logic                rx_data_lost,
   input  wire logic                cmd_valid,
   input  wire gsr_pkg::gsr_cmd_e   cmd_code,
   input  wire logic [7:0]          cmd_arg,
   input  wire logic                exec_range_err,
   input  wire logic                exec_count_err,
   input  wire logic                exec_dev_err,
   input  wire logic                cmd_unknown,
   input  wire logic                bus_cmd_invalid,
   input  wire logic                out_read_req,
   input  wire logic                out_read_done,
   input  wire logic                serial_poll_done,
   input  wire logic [7:0]          test_events,
   input  wire logic [SET_W-1:0]    saved_settings,
   input  wire logic [SET_W-1:0]    factory_settings,
   input  wire logic                nv_corrupt_pin,
   output logic                     srq_out,
   output logic                     srq_oe,
   output logic [7:0]               resp_data,
   output logic                     resp_valid,
   output logic                     resp_multi,
   output logic                     msg_avail,
   output logic [7:0]               std_event_flags,
   output logic [7:0]               std_enable_mask,
   output logic [7:0]               test_enable_mask,
   output logic                     test_summary_bit,
   output logic                     std_summary_bit,
   output logic [SET_W-1:0]         device_settings,
   output logic [`GSR_CNT_W-1:0]    line_count,
   output logic                     op_complete
);
   initial begin
      if (LINE_MAX < 1 || LINE_MAX > 127)
         $error("gsr_core: LINE_MAX out of range");
      if (SET_W < 8)
         $error("gsr_core: SET_W below reply width");
   end

   logic [7:0]            esr_r;
   logic [7:0]            ese_r;
   logic [7:0]            sre_r;
   logic [7:0]            tse_r;
   logic                  srq_r;
   logic                  polled_r;
   logic [`GSR_CNT_W-1:0] cnt_r;
   logic                  line_open_r;
   logic                  mav_r;
   logic [7:0]            resp_r;
   logic                  resp_v_r;
   logic                  multi_r;
   logic                  esb_r;
   logic                  tsb_r;
   logic [SET_W-1:0]      set_r;
   logic                  pon_r;
   logic                  nv_m_r;
   logic                  nv_s_r;
   logic                  ovf_r;
   logic                  esb_c;
   logic                  tsb_c;
   logic [7:0]            stb_c;
   logic                  rqs_c;
   logic [7:0]            esr_set_c;
   logic                  is_query_c;
   logic                  esr_read_c;
   logic                  cls_c;
   logic                  rst_cmd_c;
   gsr_pkg::gsr_oc_e      ocs_r;

   function automatic logic query_code(input gsr_pkg::gsr_cmd_e c);
      query_code = (c == gsr_pkg::GSR_CMD_ESE_Q) ||
                   (c == gsr_pkg::GSR_CMD_ESR_Q) ||
                   (c == gsr_pkg::GSR_CMD_SRE_Q) ||
                   (c == gsr_pkg::GSR_CMD_STB_Q) ||
                   (c == gsr_pkg::GSR_CMD_TSE_Q) ||
                   (c == gsr_pkg::GSR_CMD_TSR_Q) ||
                   (c == gsr_pkg::GSR_CMD_LRN_Q) ||
                   (c == gsr_pkg::GSR_CMD_OTHER_Q);
   endfunction : query_code

   gsr_summary #(.W(8)) u_esb (
      .flags   (esr_r),
      .enables (ese_r),
      .summary (esb_c)
   );
   gsr_summary #(.W(8)) u_tsb (
      .flags   (test_events),
      .enables (tse_r),
      .summary (tsb_c)
   );

   assign is_query_c = cmd_valid && query_code(cmd_code);
   assign esr_read_c = cmd_valid && (cmd_code == gsr_pkg::GSR_CMD_ESR_Q);
   assign cls_c      = cmd_valid && (cmd_code == gsr_pkg::GSR_CMD_CLS);
   assign rst_cmd_c  = cmd_valid && (cmd_code == gsr_pkg::GSR_CMD_RST);

   always_comb begin
      stb_c = `GSR_BYTE_ZERO;
      stb_c[`GSR_STB_TSB] = tsb_c;
      stb_c[`GSR_STB_MAV] = mav_r;
      stb_c[`GSR_STB_ESB] = esb_c;
      rqs_c = |(stb_c & sre_r);
      stb_c[`GSR_STB_MSS] = rqs_c;
   end

   // Corrupt-store strap comes from outside; two stages first
   // No reset: strap must already be settled when reset lifts
   always_ff @(posedge clock) begin
      nv_m_r <= nv_corrupt_pin;
      nv_s_r <= nv_m_r;
   end

   // Power-up marker, cleared one cycle after reset release
   always_ff @(posedge clock) begin
      if (!rst_b)
         pon_r <= 1'b1;
      else
         pon_r <= 1'b0;
   end

   // Event sources gathered into one set vector
   always_comb begin
      esr_set_c = `GSR_BYTE_ZERO;
      // completion flag only from the command
      esr_set_c[`GSR_EV_OPC] = cmd_valid &&
                               (cmd_code == gsr_pkg::GSR_CMD_OPC);
      esr_set_c[`GSR_EV_QYE] = (out_read_req && !mav_r) ||
                               (cmd_valid && mav_r) ||
                               (out_read_req && line_open_r);
      esr_set_c[`GSR_EV_DDE] = rx_data_lost || ovf_r;
      esr_set_c[`GSR_EV_EXE] = exec_range_err || exec_count_err ||
                               exec_dev_err;
      esr_set_c[`GSR_EV_CME] = cmd_unknown || bus_cmd_invalid;
      // power-on flag on the first cycle after reset
      esr_set_c[`GSR_EV_PON] = pon_r;
   end

   // Event register; a new event outranks a clear in the same cycle
   always_ff @(posedge clock) begin
      if (!rst_b)
         esr_r <= `GSR_BYTE_ZERO;
      // clear on read, sets still win
      else if (esr_read_c || cls_c)
         esr_r <= esr_set_c & `GSR_EV_USED;
      else
         esr_r <= (esr_r | esr_set_c) & `GSR_EV_USED;
   end

   // enable masks zero at power-up; survive reset command
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         ese_r <= `GSR_BYTE_ZERO;
         sre_r <= `GSR_BYTE_ZERO;
         tse_r <= `GSR_BYTE_ZERO;
      end else if (cmd_valid) begin
         if (cmd_code == gsr_pkg::GSR_CMD_ESE)
            ese_r <= cmd_arg;
         if (cmd_code == gsr_pkg::GSR_CMD_SRE)
            sre_r <= cmd_arg;
         if (cmd_code == gsr_pkg::GSR_CMD_TSE)
            tse_r <= cmd_arg;
      end
   end

   // per-line buffer occupancy, restarted at each terminator
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         cnt_r       <= '0;
         line_open_r <= 1'b0;
         ovf_r       <= 1'b0;
      end else begin
         ovf_r <= 1'b0;
         if (rx_char_valid) begin
            if (rx_char_term) begin
               cnt_r       <= '0;
               line_open_r <= 1'b0;
            end else if (cnt_r == `GSR_CNT_W'(LINE_MAX)) begin
               ovf_r <= 1'b1;
            end else begin
               cnt_r       <= cnt_r + `GSR_CNT_W'(1);
               line_open_r <= 1'b1;
            end
         end
      end
   end

   // response built in the parse cycle
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         resp_r   <= `GSR_BYTE_ZERO;
         resp_v_r <= 1'b0;
         multi_r  <= 1'b0;
         mav_r    <= 1'b0;
      end else begin
         resp_v_r <= is_query_c;
         if (is_query_c) begin
            mav_r <= 1'b1;
            // only the learn query is multi-unit
            multi_r <= (cmd_code == gsr_pkg::GSR_CMD_LRN_Q);
            unique case (cmd_code)
               gsr_pkg::GSR_CMD_ESE_Q: resp_r <= ese_r;
               gsr_pkg::GSR_CMD_ESR_Q: resp_r <= esr_r;
               gsr_pkg::GSR_CMD_SRE_Q: resp_r <= sre_r;
               gsr_pkg::GSR_CMD_STB_Q: resp_r <= stb_c;
               gsr_pkg::GSR_CMD_TSE_Q: resp_r <= tse_r;
               gsr_pkg::GSR_CMD_TSR_Q: resp_r <= test_events;
               default:                resp_r <= set_r[7:0];
            endcase
         end else if (out_read_done || cls_c) begin
            mav_r <= 1'b0;
         end
      end
   end

   // reset command idles the completion machine
   // sequential: completion is immediate after the command
   always_ff @(posedge clock) begin
      if (!rst_b)
         ocs_r <= gsr_pkg::GSR_OC_IDLE;
      else if (rst_cmd_c)
         ocs_r <= gsr_pkg::GSR_OC_IDLE;
      else if (cmd_valid && cmd_code == gsr_pkg::GSR_CMD_OPC)
         ocs_r <= gsr_pkg::GSR_OC_ARM;
      else
         ocs_r <= gsr_pkg::GSR_OC_IDLE;
   end

   // settings restore at power-up, factory on corruption
   always_ff @(posedge clock) begin
      if (!rst_b)
         set_r <= '0;
      else if (pon_r)
         set_r <= nv_s_r ? factory_settings : saved_settings;
      // reset command returns device settings to defaults
      else if (rst_cmd_c)
         set_r <= factory_settings;
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         srq_r    <= 1'b0;
         polled_r <= 1'b0;
      end else begin
         if (!rqs_c)
            polled_r <= 1'b0;
         else if (serial_poll_done)
            polled_r <= 1'b1;
         srq_r <= rqs_c && !polled_r && !serial_poll_done;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         esb_r <= 1'b0;
         tsb_r <= 1'b0;
      end else begin
         esb_r <= esb_c;
         tsb_r <= tsb_c;
      end
   end

   assign srq_out          = 1'b0;
   assign srq_oe           = srq_r;
   assign resp_data        = resp_r;
   assign resp_valid       = resp_v_r;
   assign resp_multi       = multi_r;
   assign msg_avail        = mav_r;
   assign std_event_flags  = esr_r;
   assign std_enable_mask  = ese_r;
   assign test_enable_mask = tse_r;
   assign test_summary_bit = tsb_r;
   assign std_summary_bit  = esb_r;
   assign device_settings  = set_r;
   assign line_count       = cnt_r;
   assign op_complete      = (ocs_r == gsr_pkg::GSR_OC_ARM);

   chk_opc_cause: assert property (
      @(posedge clock) disable iff (!rst_b)
      $rose(esr_r[`GSR_EV_OPC]) |-> $past(cmd_code) == gsr_pkg::GSR_CMD_OPC)
      else $error("completion flag set without command");
   chk_qye_nomsg: assert property (
      @(posedge clock) disable iff (!rst_b)
      out_read_req && !mav_r |=> esr_r[`GSR_EV_QYE])
      else $error("query error missed");
   chk_dde_lost: assert property (
      @(posedge clock) disable iff (!rst_b)
      rx_data_lost |=> esr_r[`GSR_EV_DDE])
      else $error("device error missed");
   chk_exe_set: assert property (
      @(posedge clock) disable iff (!rst_b)
      exec_range_err || exec_count_err || exec_dev_err |=> esr_r[`GSR_EV_EXE])
      else $error("execution error missed");
   chk_cme_set: assert property (
      @(posedge clock) disable iff (!rst_b)
      cmd_unknown || bus_cmd_invalid |=> esr_r[`GSR_EV_CME])
      else $error("command error missed");
   chk_unused_bits: assert property (
      @(posedge clock) disable iff (!rst_b)
      (esr_r & ~`GSR_EV_USED) == `GSR_BYTE_ZERO)
      else $error("unused event bit set");
   chk_esb_follow: assert property (
      @(posedge clock) disable iff (!rst_b)
      ##1 esb_r == |($past(esr_r) & $past(ese_r)))
      else $error("standard summary wrong");
   chk_tsb_follow: assert property (
      @(posedge clock) disable iff (!rst_b)
      ##1 tsb_r == |($past(test_events) & $past(tse_r)))
      else $error("test summary wrong");
   chk_srq_drop: assert property (
      @(posedge clock) disable iff (!rst_b)
      serial_poll_done |=> !srq_oe)
      else $error("request not released after poll");
   chk_srq_raise: assert property (
      @(posedge clock) disable iff (!rst_b)
      rqs_c && !polled_r && !serial_poll_done |=> srq_oe)
      else $error("request not raised");
   chk_line_cap: assert property (
      @(posedge clock) disable iff (!rst_b)
      cnt_r <= `GSR_CNT_W'(LINE_MAX))
      else $error("line buffer past capacity");
   chk_resp_multi: assert property (
      @(posedge clock) disable iff (!rst_b)
      resp_v_r && multi_r |-> $past(cmd_code) == gsr_pkg::GSR_CMD_LRN_Q)
      else $error("multi-unit reply from wrong query");
endmodule : gsr_core
`default_nettype wire

// ==== tb/gsr_ctrl_model.sv ====
// Bus controller model issuing parsed commands, reads and polls
`default_nettype none
module gsr_ctrl_model (
   input  wire logic               clock,
   output var  logic               cmd_valid,
   output var  gsr_pkg::gsr_cmd_e  cmd_code,
   output var  logic [7:0]         cmd_arg,
   output var  logic               rx_char_valid,
   output var  logic               rx_char_term,
   output var  logic               out_read_req,
   output var  logic               out_read_done,
   output var  logic               serial_poll_done
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      cmd_valid = 1'b0;
      cmd_code = gsr_pkg::GSR_CMD_NONE;
      cmd_arg = 8'h00;
      {rx_char_valid, rx_char_term} = 2'b00;
      {out_read_req, out_read_done, serial_poll_done} = 3'b000;
   end

   // One command per pulse, never overlapped
   task automatic send(input gsr_pkg::gsr_cmd_e c, input logic [7:0] a);
      @(negedge clock);
      cmd_code = c;
      cmd_arg = a;
      cmd_valid = 1'b1;
      @(negedge clock);
      cmd_valid = 1'b0;
      // Released argument must not look valid
      cmd_arg = ~a;
      @(negedge clock);
   endtask : send

   task automatic strobe(input int k, input logic t);
      @(negedge clock);
      rx_char_term = t;
      case (k)
         0: rx_char_valid = 1'b1;
         1: out_read_req = 1'b1;
         2: out_read_done = 1'b1;
         default: serial_poll_done = 1'b1;
      endcase
      @(negedge clock);
      {rx_char_valid, out_read_req, out_read_done} = 3'b000;
      serial_poll_done = 1'b0;
      rx_char_term = ~t;
      @(negedge clock);
   endtask : strobe
endmodule : gsr_ctrl_model
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the status reporting core
`include "gsr_defs.svh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam gsr_pkg::gsr_cmd_e ESRQ = gsr_pkg::GSR_CMD_ESR_Q;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic nv_corrupt_pin = 1'b0;
   logic [5:0] ev = 6'h00;
   logic [7:0] test_events = 8'h00;
   logic [7:0] saved_settings = 8'h5A;
   logic [7:0] factory_settings = 8'hA5;
   logic [7:0] evx [6] = '{8'h08, 8'h10, 8'h10, 8'h10, 8'h20, 8'h20};
   int n_fail = 0;
   int checks = 0;
   logic cmd_valid, rx_char_valid, rx_char_term, out_read_req;
   logic out_read_done, serial_poll_done, srq_out, srq_oe;
   logic resp_valid, resp_multi, msg_avail, op_complete;
   logic test_summary_bit, std_summary_bit;
   logic [7:0] cmd_arg, resp_data, std_event_flags, std_enable_mask;
   logic [7:0] test_enable_mask, device_settings;
   logic [6:0] line_count;
   gsr_pkg::gsr_cmd_e cmd_code;

   always #5 clock = ~clock;

   gsr_core gsr_core_i (
      .clock, .rst_b, .rx_char_valid, .rx_char_term,
      .rx_data_lost(ev[0]), .cmd_valid, .cmd_code, .cmd_arg,
      .exec_range_err(ev[1]), .exec_count_err(ev[2]),
      .exec_dev_err(ev[3]), .cmd_unknown(ev[4]),
      .bus_cmd_invalid(ev[5]), .out_read_req, .out_read_done,
      .serial_poll_done, .test_events, .saved_settings,
      .factory_settings, .nv_corrupt_pin, .srq_out, .srq_oe,
      .resp_data, .resp_valid, .resp_multi, .msg_avail,
      .std_event_flags, .std_enable_mask, .test_enable_mask,
      .test_summary_bit, .std_summary_bit, .device_settings,
      .line_count, .op_complete
   );

   gsr_ctrl_model gsr_ctrl_model_i (
      .clock, .cmd_valid, .cmd_code, .cmd_arg, .rx_char_valid,
      .rx_char_term, .out_read_req, .out_read_done, .serial_poll_done
   );

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic print_verdict();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict

   task automatic idle(input int n);
      repeat (n) @(negedge clock);
   endtask : idle

   task automatic fire(input int k);
      @(negedge clock);
      ev[k] = 1'b1;
      @(negedge clock);
      ev = 6'h00;
   endtask : fire

   // Answer lands one cycle after parse; reply then marked read
   task automatic query(input gsr_pkg::gsr_cmd_e c, input logic [7:0] exp,
                        input logic multi, input bit dat);
      // Reply strobe stands one cycle only: look while it stands
      fork
         gsr_ctrl_model_i.send(c, 8'h00);
         begin
            repeat (2) @(negedge clock);
            chk({7'h00, resp_valid}, 8'h01);
            if (dat) chk(resp_data, exp);
            chk({7'h00, resp_multi}, {7'h00, multi});
         end
      join
      chk({7'h00, resp_valid}, 8'h00);
      gsr_ctrl_model_i.strobe(2, 1'b0);
   endtask : query

   initial begin
      #100us;
      n_fail++;
      print_verdict();
   end

   initial begin
      repeat (20) @(negedge clock);
      rst_b = 1'b1;
      idle(4);
      chk(std_event_flags, 8'h80);
      chk(std_enable_mask, 8'h00);
      chk(test_enable_mask, 8'h00);
      chk(device_settings, 8'h5A);
      query(ESRQ, 8'h80, 1'b0, 1'b1);
      chk(std_event_flags, 8'h00);
      for (int k = 0; k < 6; k++) begin
         fire(k);
         idle(1);
         query(ESRQ, evx[k], 1'b0, 1'b1);
      end
      fork
         gsr_ctrl_model_i.send(gsr_pkg::GSR_CMD_OPC, 8'h00);
         begin
            repeat (2) @(negedge clock);
            chk({7'h00, op_complete}, 8'h01);
         end
      join
      chk({7'h00, op_complete}, 8'h00);
      query(ESRQ, 8'h01, 1'b0, 1'b1);
      // Enable command sent over an unread reply, then read with nothing pending
      gsr_ctrl_model_i.send(ESRQ, 8'h00);
      chk({7'h00, msg_avail}, 8'h01);
      gsr_ctrl_model_i.send(gsr_pkg::GSR_CMD_ESE, 8'h00);
      gsr_ctrl_model_i.strobe(2, 1'b0);
      query(ESRQ, 8'h04, 1'b0, 1'b1);
      gsr_ctrl_model_i.strobe(1, 1'b0);
      query(ESRQ, 8'h04, 1'b0, 1'b1);
      repeat (`GSR_LINE_MAX) gsr_ctrl_model_i.strobe(0, 1'b0);
      chk({1'b0, line_count}, 8'(`GSR_LINE_MAX));
      gsr_ctrl_model_i.strobe(0, 1'b0);
      query(ESRQ, 8'h08, 1'b0, 1'b1);
      gsr_ctrl_model_i.strobe(0, 1'b1);
      chk({1'b0, line_count}, 8'h00);
      // Read request against an open line while a reply waits
      gsr_ctrl_model_i.send(ESRQ, 8'h00);
      gsr_ctrl_model_i.strobe(0, 1'b0);
      gsr_ctrl_model_i.strobe(1, 1'b0);
      gsr_ctrl_model_i.strobe(2, 1'b0);
      query(ESRQ, 8'h04, 1'b0, 1'b1);
      gsr_ctrl_model_i.strobe(0, 1'b1);
      gsr_ctrl_model_i.send(gsr_pkg::GSR_CMD_ESE, 8'h20);
      gsr_ctrl_model_i.send(gsr_pkg::GSR_CMD_SRE, 8'h20);
      query(gsr_pkg::GSR_CMD_SRE_Q, 8'h20, 1'b0, 1'b1);
      query(gsr_pkg::GSR_CMD_ESE_Q, 8'h20, 1'b0, 1'b1);
      chk({7'h00, srq_oe}, 8'h00);
      fire(4);
      idle(4);
      chk({7'h00, std_summary_bit}, 8'h01);
      chk({6'h00, srq_out, srq_oe}, 8'h01);
      query(gsr_pkg::GSR_CMD_STB_Q, 8'h60, 1'b0, 1'b1);
      gsr_ctrl_model_i.strobe(3, 1'b0);
      chk({7'h00, srq_oe}, 8'h00);
      query(ESRQ, 8'h20, 1'b0, 1'b1);
      chk({7'h00, std_summary_bit}, 8'h00);
      fire(5);
      idle(4);
      chk({7'h00, srq_oe}, 8'h01);
      query(ESRQ, 8'h20, 1'b0, 1'b1);
      chk({7'h00, srq_oe}, 8'h00);
      gsr_ctrl_model_i.send(gsr_pkg::GSR_CMD_TSE, 8'h05);
      query(gsr_pkg::GSR_CMD_TSE_Q, 8'h05, 1'b0, 1'b1);
      test_events = 8'h04;
      idle(2);
      chk({7'h00, test_summary_bit}, 8'h01);
      query(gsr_pkg::GSR_CMD_TSR_Q, 8'h04, 1'b0, 1'b1);
      test_events = 8'h02;
      idle(2);
      chk({7'h00, test_summary_bit}, 8'h00);
      query(gsr_pkg::GSR_CMD_LRN_Q, 8'h5A, 1'b1, 1'b1);
      query(gsr_pkg::GSR_CMD_OTHER_Q, 8'h5A, 1'b0, 1'b1);
      // Clearing every condition also drops the request line
      fire(4);
      idle(4);
      chk({7'h00, srq_oe}, 8'h01);
      gsr_ctrl_model_i.send(gsr_pkg::GSR_CMD_CLS, 8'h00);
      chk(std_event_flags, 8'h00);
      chk({7'h00, srq_oe}, 8'h00);
      gsr_ctrl_model_i.send(gsr_pkg::GSR_CMD_RST, 8'h00);
      idle(2);
      chk(device_settings, 8'hA5);
      chk(std_enable_mask, 8'h20);
      chk(test_enable_mask, 8'h05);
      // Corrupt store at power-up falls back to factory values
      factory_settings = 8'h3C;
      nv_corrupt_pin = 1'b1;
      rst_b = 1'b0;
      idle(4);
      rst_b = 1'b1;
      idle(4);
      chk(device_settings, 8'h3C);
      chk(std_enable_mask, 8'h00);
      chk(std_event_flags, 8'h80);
      print_verdict();
   end
endmodule : tb
`default_nettype wire
